//--- hw/code_protection_pkg.sv
// Package for the program memory protection gate: address map, config byte
// addresses, bit positions and erase defaults. Used by the gate and its bench.
package code_protection_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int NUM_BLOCKS = 4;

  // Configuration byte addresses
  localparam logic [ADDR_W-1:0] CFG_BLOCK_CP_ADDR   = 21'h300008;
  localparam logic [ADDR_W-1:0] CFG_BOOT_CP_ADDR    = 21'h300009;
  localparam logic [ADDR_W-1:0] CFG_BLOCK_WP_ADDR   = 21'h30000a;
  localparam logic [ADDR_W-1:0] CFG_SPECIAL_WP_ADDR = 21'h30000b;
  localparam logic [ADDR_W-1:0] CFG_BLOCK_TR_ADDR   = 21'h30000c;
  localparam logic [ADDR_W-1:0] CFG_BOOT_TR_ADDR    = 21'h30000d;
  localparam logic [ADDR_W-1:0] CFG_FIRST_ADDR      = 21'h300000;
  localparam logic [ADDR_W-1:0] CFG_LAST_ADDR       = 21'h3000ff;

  // Identification words
  localparam logic [ADDR_W-1:0] ID_FIRST_ADDR = 21'h200000;
  localparam logic [ADDR_W-1:0] ID_LAST_ADDR  = 21'h200007;

  // Block boundaries: boot block, then four blocks on binary boundaries
  localparam logic [ADDR_W-1:0] BOOT_END   = 21'h000800;
  localparam logic [ADDR_W-1:0] BLOCK0_END = 21'h004000;
  localparam logic [ADDR_W-1:0] BLOCK1_END = 21'h008000;
  localparam logic [ADDR_W-1:0] BLOCK2_END = 21'h00c000;
  localparam logic [ADDR_W-1:0] BLOCK3_END = 21'h010000;

  // Bit positions
  localparam int BOOT_READ_LOCK_BIT   = 6;
  localparam int EEPROM_READ_LOCK_BIT = 7;
  localparam int EEPROM_WRITE_LOCK_BIT = 7;
  localparam int BOOT_WRITE_LOCK_BIT  = 6;
  localparam int CONFIG_WRITE_LOCK_BIT = 5;
  localparam int BOOT_FOREIGN_READ_LOCK_BIT = 6;

  // Implemented-bit masks and erased value (all implemented bits one)
  localparam logic [DATA_W-1:0] BLOCK_MASK   = 8'h0f;
  localparam logic [DATA_W-1:0] BOOT_CP_MASK = 8'hc0;
  localparam logic [DATA_W-1:0] SPEC_WP_MASK = 8'he0;
  localparam logic [DATA_W-1:0] BOOT_TR_MASK = 8'h40;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;

  // Block index; BLK_NONE covers addresses outside user memory
  typedef enum logic [2:0] {
    BLK_BOOT, BLK_0, BLK_1, BLK_2, BLK_3, BLK_NONE
  } block_e;

endpackage

//--- hw/code_protection_gate.sv
// Protection gate for program memory, data EEPROM, config bytes and ID words.
// Assumes memories answer combinationally and one request stands per cycle.
//
// Notes on behaviour
// - Program memory splits into boot block plus four blocks on binary bounds.
// - Each block has read lock, write lock and foreign read lock bits.
// - Block read lock gates only external programmer accesses, not execution.
// - Block write lock at zero rejects table writes into that block.
// - Foreign read lock zero still allows reads from code inside the block.
// - Foreign read lock zero returns zeros to reads from outside block.
// - Lock bits may be written one to zero, never zero to one.
// - Lock bits return to one only by reset, chip erase or block erase.
// - Erase commands are accepted only from the external programming port.
// - EEPROM read lock blocks external EEPROM reads and writes.
// - EEPROM write lock blocks internal and external EEPROM writes.
// - CPU reads of data EEPROM are always allowed.
// - Config write lock guards config bytes; it is read-only to code.
// - Config write lock changes only through reset or the external programming port.
// - Table access reaches any program location, subject to block locks.
// - Table access reaches config bytes and reads identification words.
// - Eight identification bytes accessible in normal and programming modes.
// - Identification bytes readable even while code protection is active.
// - Read locks: blocks in bits 3..0, boot bit 6, EEPROM bit 7 next byte.
// - Write locks: blocks bits 3..0; EEPROM 7, boot 6, config 5 next byte.
// - Foreign read locks: blocks bits 3..0, boot bit 6 of next byte.
`timescale 1ns/10ps
module code_protection_gate (
  // Clock and reset
  input  wire logic                                    mclk,
  input  wire logic                                    reset,
  // CPU table access
  input  wire logic                                    cpu_req,
  input  wire logic                                    cpu_write,
  input  wire logic [code_protection_pkg::ADDR_W-1:0]  cpu_addr,
  input  wire logic [code_protection_pkg::ADDR_W-1:0]  cpu_fetch_addr,
  input  wire logic [code_protection_pkg::DATA_W-1:0]  cpu_wdata,
  output logic                                         cpu_ack,
  output logic                                         cpu_denied,
  output logic [code_protection_pkg::DATA_W-1:0]       cpu_rdata,
  // CPU data EEPROM access
  input  wire logic                                    cpu_ee_req,
  input  wire logic                                    cpu_ee_write,
  output logic                                         cpu_ee_grant,
  // External programmer
  input  wire logic                                    ext_req,
  input  wire logic                                    ext_write,
  input  wire logic                                    ext_ee,
  input  wire logic [code_protection_pkg::ADDR_W-1:0]  ext_addr,
  input  wire logic [code_protection_pkg::DATA_W-1:0]  ext_wdata,
  input  wire logic                                    ext_chip_erase,
  input  wire logic                                    ext_block_erase,
  input  wire logic [2:0]                              ext_erase_block,
  output logic                                         ext_ack,
  output logic                                         ext_denied,
  output logic                                         ext_ee_grant,
  output logic [code_protection_pkg::DATA_W-1:0]       ext_rdata,
  // Memory array
  input  wire logic [code_protection_pkg::DATA_W-1:0]  mem_rdata,
  output logic                                         mem_we,
  output logic [code_protection_pkg::ADDR_W-1:0]       mem_addr,
  output logic [code_protection_pkg::DATA_W-1:0]       mem_wdata
);
  import code_protection_pkg::*;

  logic [DATA_W-1:0] cp_blk_q, cp_boot_q, wp_blk_q, wp_spec_q, tr_blk_q, tr_boot_q;
  logic [DATA_W-1:0] cfg_rd;
  block_e            tgt_blk, fetch_blk, ext_blk;
  logic              tgt_is_cfg, tgt_is_id, ext_is_cfg, ext_is_id;
  logic              cpu_ok, ext_ok, cpu_zero, cpu_cfg_wr, ext_cfg_wr;
  logic              erase_chip, erase_blk;
  logic [2:0]        erase_sel;
  logic              cfg_we, boot_erase;
  logic [ADDR_W-1:0] cfg_waddr;
  logic [DATA_W-1:0] cfg_wdata, blk_erase_bits;
  localparam logic [DATA_W-1:0] CFG_LOCK_ONE = DATA_W'(1) << CONFIG_WRITE_LOCK_BIT;

  // Address to block
  function automatic block_e block_of(input logic [ADDR_W-1:0] a);
    if (a < BOOT_END)        block_of = BLK_BOOT;
    else if (a < BLOCK0_END) block_of = BLK_0;
    else if (a < BLOCK1_END) block_of = BLK_1;
    else if (a < BLOCK2_END) block_of = BLK_2;
    else if (a < BLOCK3_END) block_of = BLK_3;
    else                     block_of = BLK_NONE;
  endfunction

  // Select one lock bit for a block
  function automatic logic lock_of(input block_e b, input logic [DATA_W-1:0] blk,
                                   input logic boot);
    unique case (b)
      BLK_BOOT: lock_of = boot;
      BLK_0:    lock_of = blk[0];
      BLK_1:    lock_of = blk[1];
      BLK_2:    lock_of = blk[2];
      BLK_3:    lock_of = blk[3];
      default:  lock_of = 1'b1;
    endcase
  endfunction

  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Config byte readback
  function automatic logic [DATA_W-1:0] cfg_byte(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] c0, input logic [DATA_W-1:0] c1,
      input logic [DATA_W-1:0] c2, input logic [DATA_W-1:0] c3,
      input logic [DATA_W-1:0] c4, input logic [DATA_W-1:0] c5);
    unique case (a)
      CFG_BLOCK_CP_ADDR:   cfg_byte = c0;
      CFG_BOOT_CP_ADDR:    cfg_byte = c1;
      CFG_BLOCK_WP_ADDR:   cfg_byte = c2;
      CFG_SPECIAL_WP_ADDR: cfg_byte = c3;
      CFG_BLOCK_TR_ADDR:   cfg_byte = c4;
      CFG_BOOT_TR_ADDR:    cfg_byte = c5;
      default:             cfg_byte = ZERO_BYTE;
    endcase
  endfunction

  // Clears allowed, sets ignored
  function automatic logic [DATA_W-1:0] clear_only(input logic [DATA_W-1:0] cur,
      input logic [DATA_W-1:0] wr, input logic [DATA_W-1:0] mask);
    clear_only = cur & (wr | ~mask);
  endfunction

  assign tgt_blk    = block_of(cpu_addr);
  assign fetch_blk  = block_of(cpu_fetch_addr);
  assign ext_blk    = block_of(ext_addr);
  assign tgt_is_cfg = in_range(cpu_addr, CFG_FIRST_ADDR, CFG_LAST_ADDR);
  assign tgt_is_id  = in_range(cpu_addr, ID_FIRST_ADDR, ID_LAST_ADDR);
  assign ext_is_cfg = in_range(ext_addr, CFG_FIRST_ADDR, CFG_LAST_ADDR);
  assign ext_is_id  = in_range(ext_addr, ID_FIRST_ADDR, ID_LAST_ADDR);
  assign cfg_rd     = cfg_byte(cpu_addr, cp_blk_q, cp_boot_q, wp_blk_q, wp_spec_q,
                               tr_blk_q, tr_boot_q);

  // CPU access decision; read lock plays no part here
  always_comb begin
    cpu_ok     = 1'b1;
    cpu_zero   = 1'b0;
    cpu_cfg_wr = 1'b0;
    if (tgt_is_id) begin
      cpu_ok = 1'b1;
    end else if (tgt_is_cfg) begin
      cpu_ok     = !cpu_write || wp_spec_q[CONFIG_WRITE_LOCK_BIT];
      cpu_cfg_wr = cpu_req && cpu_write && cpu_ok;
    end else if (tgt_blk != BLK_NONE) begin
      if (cpu_write) begin
        cpu_ok = lock_of(tgt_blk, wp_blk_q, wp_spec_q[BOOT_WRITE_LOCK_BIT]);
      end else begin
        // Foreign fetch reads zero when locked; own block reads through
        cpu_zero = (fetch_blk != tgt_blk) &&
                   !lock_of(tgt_blk, tr_blk_q, tr_boot_q[BOOT_FOREIGN_READ_LOCK_BIT]);
      end
    end
  end

  // External programmer decision
  always_comb begin
    ext_ok     = 1'b1;
    ext_cfg_wr = 1'b0;
    if (ext_ee) begin
      ext_ok = cp_boot_q[EEPROM_READ_LOCK_BIT] &&
               (!ext_write || wp_spec_q[EEPROM_WRITE_LOCK_BIT]);
    end else if (ext_is_id) begin
      ext_ok = 1'b1;
    end else if (ext_is_cfg) begin
      ext_ok     = !ext_write || wp_spec_q[CONFIG_WRITE_LOCK_BIT];
      ext_cfg_wr = ext_req && ext_write && ext_ok;
    end else if (ext_blk != BLK_NONE) begin
      ext_ok = lock_of(ext_blk, cp_blk_q, cp_boot_q[BOOT_READ_LOCK_BIT]) &&
               (!ext_write || lock_of(ext_blk, wp_blk_q, wp_spec_q[BOOT_WRITE_LOCK_BIT]));
    end
  end

  assign erase_chip = ext_chip_erase;
  assign erase_blk  = ext_block_erase;
  assign erase_sel  = ext_erase_block;
  assign boot_erase = erase_blk && (erase_sel == 3'(BLK_BOOT));

  // Block erase as a one-hot mask over the four block lock bits
  for (genvar gi = 0; gi < DATA_W; gi++) begin : g_blk_erase
    if (gi < NUM_BLOCKS) begin : g_used
      assign blk_erase_bits[gi] = erase_blk && (erase_sel == 3'(int'(BLK_0) + gi));
    end else begin : g_spare
      assign blk_erase_bits[gi] = 1'b0;
    end
  end

  // One config write a cycle, programmer first; CPU never clears the config lock
  always_comb begin
    cfg_we    = ext_cfg_wr || cpu_cfg_wr;
    cfg_waddr = cpu_addr;
    cfg_wdata = cpu_wdata | CFG_LOCK_ONE;
    if (ext_cfg_wr) begin
      cfg_waddr = ext_addr;
      cfg_wdata = ext_wdata;
    end
  end

  // Block read locks
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cp_blk_q <= BLOCK_MASK;
    end else if (erase_chip) begin
      cp_blk_q <= BLOCK_MASK;
    end else if (erase_blk) begin
      cp_blk_q <= cp_blk_q | blk_erase_bits;
    end else if (cfg_we && cfg_waddr == CFG_BLOCK_CP_ADDR) begin
      cp_blk_q <= clear_only(cp_blk_q, cfg_wdata, BLOCK_MASK);
    end
  end

  // Boot and EEPROM read locks
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cp_boot_q <= BOOT_CP_MASK;
    end else if (erase_chip) begin
      cp_boot_q <= BOOT_CP_MASK;
    end else if (erase_blk) begin
      cp_boot_q[BOOT_READ_LOCK_BIT] <= cp_boot_q[BOOT_READ_LOCK_BIT] || boot_erase;
    end else if (cfg_we && cfg_waddr == CFG_BOOT_CP_ADDR) begin
      cp_boot_q <= clear_only(cp_boot_q, cfg_wdata, BOOT_CP_MASK);
    end
  end

  // Block write locks
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wp_blk_q <= BLOCK_MASK;
    end else if (erase_chip) begin
      wp_blk_q <= BLOCK_MASK;
    end else if (erase_blk) begin
      wp_blk_q <= wp_blk_q | blk_erase_bits;
    end else if (cfg_we && cfg_waddr == CFG_BLOCK_WP_ADDR) begin
      wp_blk_q <= clear_only(wp_blk_q, cfg_wdata, BLOCK_MASK);
    end
  end

  // EEPROM, boot and config write locks
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wp_spec_q <= SPEC_WP_MASK;
    end else if (erase_chip) begin
      wp_spec_q <= SPEC_WP_MASK;
    end else if (erase_blk) begin
      wp_spec_q[BOOT_WRITE_LOCK_BIT] <= wp_spec_q[BOOT_WRITE_LOCK_BIT] || boot_erase;
    end else if (cfg_we && cfg_waddr == CFG_SPECIAL_WP_ADDR) begin
      wp_spec_q <= clear_only(wp_spec_q, cfg_wdata, SPEC_WP_MASK);
    end
  end

  // Block foreign read locks
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tr_blk_q <= BLOCK_MASK;
    end else if (erase_chip) begin
      tr_blk_q <= BLOCK_MASK;
    end else if (erase_blk) begin
      tr_blk_q <= tr_blk_q | blk_erase_bits;
    end else if (cfg_we && cfg_waddr == CFG_BLOCK_TR_ADDR) begin
      tr_blk_q <= clear_only(tr_blk_q, cfg_wdata, BLOCK_MASK);
    end
  end

  // Boot foreign read lock
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tr_boot_q <= BOOT_TR_MASK;
    end else if (erase_chip) begin
      tr_boot_q <= BOOT_TR_MASK;
    end else if (erase_blk) begin
      tr_boot_q[BOOT_FOREIGN_READ_LOCK_BIT] <= tr_boot_q[BOOT_FOREIGN_READ_LOCK_BIT] ||
                                               boot_erase;
    end else if (cfg_we && cfg_waddr == CFG_BOOT_TR_ADDR) begin
      tr_boot_q <= clear_only(tr_boot_q, cfg_wdata, BOOT_TR_MASK);
    end
  end

  // CPU answers, one cycle after request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_ack    <= 1'b0;
      cpu_denied <= 1'b0;
      cpu_rdata  <= ZERO_BYTE;
    end else begin
      cpu_ack    <= cpu_req && cpu_ok;
      cpu_denied <= cpu_req && !cpu_ok;
      if (cpu_req && !cpu_write) begin
        cpu_rdata <= cpu_zero ? ZERO_BYTE : (tgt_is_cfg ? cfg_rd : mem_rdata);
      end
    end
  end

  // EEPROM grants
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_ee_grant <= 1'b0;
      ext_ee_grant <= 1'b0;
    end else begin
      cpu_ee_grant <= cpu_ee_req &&
                      (!cpu_ee_write || wp_spec_q[EEPROM_WRITE_LOCK_BIT]);
      ext_ee_grant <= ext_req && ext_ee && ext_ok;
    end
  end

  // Programmer answers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ext_ack    <= 1'b0;
      ext_denied <= 1'b0;
      ext_rdata  <= ZERO_BYTE;
    end else begin
      ext_ack    <= ext_req && ext_ok;
      ext_denied <= ext_req && !ext_ok;
      if (ext_req && !ext_write) begin
        ext_rdata <= !ext_ok ? ZERO_BYTE :
                     (ext_is_cfg ? cfg_byte(ext_addr, cp_blk_q, cp_boot_q, wp_blk_q,
                                            wp_spec_q, tr_blk_q, tr_boot_q) : mem_rdata);
      end
    end
  end

  // Memory port; programmer wins when both request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= ZERO_BYTE;
    end else begin
      mem_we    <= (ext_req && ext_write && ext_ok && !ext_is_cfg && !ext_ee) ||
                   (!ext_req && cpu_req && cpu_write && cpu_ok && !tgt_is_cfg);
      mem_addr  <= ext_req ? ext_addr : cpu_addr;
      mem_wdata <= ext_req ? ext_wdata : cpu_wdata;
    end
  end

endmodule

//--- test/code_protection_gate_asserts.sv
// Port-level assertions for the code protection gate.
// Bound to the gate from the bench top file; sees gate ports only.
`timescale 1ns/10ps
module code_protection_gate_asserts (
  // Clock and reset
  input wire logic                                   mclk,
  input wire logic                                   reset,
  // CPU side
  input wire logic                                   cpu_req,
  input wire logic                                   cpu_write,
  input wire logic [code_protection_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic [code_protection_pkg::DATA_W-1:0] cpu_wdata,
  input wire logic                                   cpu_ack,
  input wire logic                                   cpu_denied,
  input wire logic                                   cpu_ee_req,
  input wire logic                                   cpu_ee_write,
  input wire logic                                   cpu_ee_grant,
  // Programmer side
  input wire logic                                   ext_req,
  input wire logic                                   ext_ack,
  input wire logic                                   ext_denied,
  // Memory write port
  input wire logic                                   mem_we,
  input wire logic [code_protection_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [code_protection_pkg::DATA_W-1:0] mem_wdata
);
  import code_protection_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // CPU write into user memory with the port free of the programmer
  sequence s_cpu_wr;
    cpu_req && cpu_write && !ext_req && cpu_addr < BLOCK3_END;
  endsequence
  sequence s_granted_wr;
    cpu_ack && mem_we;
  endsequence
  a_cpu_one_answer: assert property (cpu_req |=> cpu_ack != cpu_denied)
    else $error("cpu request without exactly one answer");
  a_cpu_idle_quiet: assert property (!cpu_req |=> !cpu_ack && !cpu_denied)
    else $error("cpu answer without request");
  a_ext_one_answer: assert property (ext_req |=> ext_ack != ext_denied)
    else $error("programmer request without exactly one answer");
  a_ext_idle_quiet: assert property (!ext_req |=> !ext_ack && !ext_denied)
    else $error("programmer answer without request");
  a_ee_read_grant: assert property (cpu_ee_req && !cpu_ee_write |=> cpu_ee_grant)
    else $error("cpu eeprom read not granted");
  a_id_read_ok: assert property (cpu_req && !cpu_write &&
      cpu_addr inside {[ID_FIRST_ADDR:ID_LAST_ADDR]} |=> cpu_ack)
    else $error("id read not accepted");
  a_wr_reaches_mem: assert property (s_cpu_wr |=> mem_we == cpu_ack)
    else $error("memory write strobe disagrees with answer");
  a_wr_payload: assert property (s_cpu_wr ##1 s_granted_wr |->
      mem_wdata == $past(cpu_wdata) && mem_addr == $past(cpu_addr))
    else $error("memory write carries wrong address or data");
  a_denied_no_write: assert property (s_cpu_wr ##1 cpu_denied |-> !mem_we)
    else $error("denied write reached memory");
endmodule

//--- test/program_memory_model.sv
// Byte-wide memory behind the gate, read combinationally.
// Only the low address byte is decoded; contents start as a pattern.
`timescale 1ns/10ps
module program_memory_model (
  // Clock
  input  wire logic        mclk,
  // Write port
  input  wire logic        we,
  input  wire logic [20:0] waddr,
  input  wire logic [7:0]  wdata,
  // Read port
  input  wire logic [20:0] raddr,
  output logic      [7:0]  rdata
);
  logic [7:0] mem_q [256];
  initial for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'h5a;
  always @(posedge mclk) if (we) mem_q[waddr[7:0]] <= wdata;
  assign rdata = mem_q[raddr[7:0]];
endmodule

//--- test/code_protection_gate_tb_top.sv
// Self-checking bench for the code protection gate.
// Drives CPU and programmer requests 1 ns after the rising edge.
`timescale 1ns/10ps
module code_protection_gate_tb_top;
  import code_protection_pkg::*;
  localparam logic [20:0] B0 = 21'h001020, B1 = 21'h004030, B2 = 21'h008040;
  localparam logic [20:0] B3 = 21'h00c050, BT = 21'h000060;
  logic              mclk = 0, reset = 1, mem_we;
  logic              cpu_req = 0, cpu_write = 0, cpu_ee_req = 0, cpu_ee_write = 0;
  logic              ext_req = 0, ext_write = 0, ext_ee = 0;
  logic              ext_chip_erase = 0, ext_block_erase = 0;
  logic              cpu_ack, cpu_denied, cpu_ee_grant, ext_ack, ext_denied, ext_ee_grant;
  logic [2:0]        ext_erase_block = '0;
  logic [ADDR_W-1:0] cpu_addr = '0, cpu_fetch_addr = '0, ext_addr = '0, mem_addr;
  logic [DATA_W-1:0] cpu_wdata = '0, ext_wdata = '0, cpu_rdata, ext_rdata, mem_rdata;
  logic [DATA_W-1:0] mem_wdata, rd;
  int                n_errors = 0, n_tests = 0;
  code_protection_gate i_code_protection_gate (.mclk(mclk), .reset(reset),
    .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
    .cpu_fetch_addr(cpu_fetch_addr), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack),
    .cpu_denied(cpu_denied), .cpu_rdata(cpu_rdata), .cpu_ee_req(cpu_ee_req),
    .cpu_ee_write(cpu_ee_write), .cpu_ee_grant(cpu_ee_grant), .ext_req(ext_req),
    .ext_write(ext_write), .ext_ee(ext_ee), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_chip_erase(ext_chip_erase), .ext_block_erase(ext_block_erase),
    .ext_erase_block(ext_erase_block), .ext_ack(ext_ack), .ext_denied(ext_denied),
    .ext_ee_grant(ext_ee_grant), .ext_rdata(ext_rdata), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
  program_memory_model i_program_memory_model (.mclk(mclk), .we(mem_we),
    .waddr(mem_addr), .wdata(mem_wdata), .raddr(ext_req ? ext_addr : cpu_addr),
    .rdata(mem_rdata));
  initial forever #25 mclk = ~mclk;
  function automatic logic [7:0] pat(input logic [20:0] ad);
    return ad[7:0] ^ 8'h5a;
  endfunction
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cpu_chk(input logic w, input logic [20:0] ad, input logic [20:0] f,
                         input logic [7:0] wd, input logic ok);
    @(posedge mclk);
    #1;
    {cpu_req, cpu_write, cpu_addr, cpu_fetch_addr, cpu_wdata} = {1'b1, w, ad, f, wd};
    @(posedge mclk);
    #1;
    cpu_req = 0;
    rd = cpu_rdata;
    check({6'h0, cpu_ack, cpu_denied}, ok ? 8'h02 : 8'h01);
  endtask
  task automatic cpu_rd(input logic [20:0] ad, input logic [20:0] f, input logic [7:0] e);
    cpu_chk(0, ad, f, 8'h00, 1);
    check(rd, e);
  endtask
  task automatic ext_chk(input logic w, input logic ee, input logic [20:0] ad,
                         input logic [7:0] wd, input logic ok);
    @(posedge mclk);
    #1;
    {ext_req, ext_write, ext_ee, ext_addr, ext_wdata} = {1'b1, w, ee, ad, wd};
    @(posedge mclk);
    #1;
    ext_req = 0;
    rd = ext_rdata;
    check({6'h0, ext_ack, ext_denied}, ok ? 8'h02 : 8'h01);
    if (ee) check({7'h0, ext_ee_grant}, {7'h0, ok});
  endtask
  task automatic ee_chk(input logic w, input logic ok);
    @(posedge mclk);
    #1;
    {cpu_ee_req, cpu_ee_write} = {1'b1, w};
    @(posedge mclk);
    #1;
    cpu_ee_req = 0;
    check({7'h0, cpu_ee_grant}, {7'h0, ok});
  endtask
  task automatic erase(input logic chip, input logic [2:0] blk);
    @(posedge mclk);
    #1;
    {ext_chip_erase, ext_block_erase, ext_erase_block} = {chip, !chip, blk};
    @(posedge mclk);
    #1;
    {ext_chip_erase, ext_block_erase} = 2'b00;
  endtask
  task automatic cfg_defaults();
    logic [7:0] e [6] = '{8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
    for (int i = 0; i < 6; i++) cpu_rd(CFG_BLOCK_CP_ADDR + 21'(i), B0, e[i]);
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    reset = 0;
    cfg_defaults();
    cpu_rd(B1, B0, pat(B1));
    cpu_chk(1, B1, B0, 8'h3c, 1);
    cpu_rd(B1, B0, 8'h3c);
    cpu_chk(1, CFG_BLOCK_WP_ADDR, B0, 8'h0d, 1);
    cpu_chk(1, CFG_BLOCK_WP_ADDR, B0, 8'h0f, 1);
    cpu_rd(CFG_BLOCK_WP_ADDR, B0, 8'h0d);
    cpu_chk(1, B1, B0, 8'h77, 0);
    cpu_rd(B1, B0, 8'h3c);
    cpu_chk(1, CFG_BLOCK_TR_ADDR, B0, 8'h0e, 1);
    cpu_rd(B0, B1, 8'h00);
    cpu_rd(B0, B0 + 21'h2, pat(B0));
    cpu_chk(1, CFG_BOOT_TR_ADDR, B0, 8'h00, 1);
    cpu_rd(BT, B0, 8'h00);
    cpu_chk(1, CFG_BLOCK_CP_ADDR, B0, 8'h0b, 1);
    cpu_rd(B2, B2, pat(B2));
    ext_chk(0, 0, B2, 8'h00, 0);
    check(rd, ZERO_BYTE);
    ext_chk(0, 0, B3, 8'h00, 1);
    check(rd, pat(B3));
    ext_chk(0, 0, CFG_BLOCK_CP_ADDR, 8'h00, 1);
    check(rd, 8'h0b);
    ee_chk(1, 1);
    cpu_chk(1, CFG_SPECIAL_WP_ADDR, B0, 8'h40, 1);
    cpu_rd(CFG_SPECIAL_WP_ADDR, B0, 8'h60);
    ee_chk(1, 0);
    ext_chk(1, 1, 21'h10, 8'h11, 0);
    ext_chk(0, 1, 21'h10, 8'h00, 1);
    cpu_chk(1, CFG_BOOT_CP_ADDR, B0, 8'h40, 1);
    ext_chk(0, 1, 21'h10, 8'h00, 0);
    ee_chk(0, 1);
    ext_chk(1, 0, CFG_SPECIAL_WP_ADDR, 8'h40, 1);
    cpu_rd(CFG_SPECIAL_WP_ADDR, B0, 8'h40);
    cpu_chk(1, CFG_BLOCK_WP_ADDR, B0, 8'h00, 0);
    cpu_rd(CFG_BLOCK_WP_ADDR, B0, 8'h0d);
    cpu_chk(0, ID_LAST_ADDR, B0, 8'h00, 1);
    cpu_chk(1, ID_FIRST_ADDR, B0, 8'ha5, 1);
    cpu_rd(ID_FIRST_ADDR, B0, 8'ha5);
    ext_chk(0, 0, ID_FIRST_ADDR, 8'h00, 1);
    erase(0, 3'h3);
    cpu_rd(CFG_BLOCK_CP_ADDR, B0, 8'h0f);
    erase(1, 3'h0);
    cfg_defaults();
    stop_test();
  end
endmodule
bind code_protection_gate code_protection_gate_asserts i_code_protection_gate_asserts (
  .mclk, .reset, .cpu_req, .cpu_write, .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_denied,
  .cpu_ee_req, .cpu_ee_write, .cpu_ee_grant, .ext_req, .ext_ack, .ext_denied,
  .mem_we, .mem_addr, .mem_wdata);
